//--- iop_consts.svh
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IOP_IDX_PA_DATA 6'h00
`define IOP_IDX_PB_DATA 6'h01
`define IOP_IDX_PA_DIR 6'h02
`define IOP_IDX_PB_DIR 6'h03
`define IOP_IDX_PA_PU 6'h04
`define IOP_IDX_PB_PU 6'h05
`define IOP_IDX_PD 6'h06
`define IOP_IDX_PB_OD 6'h07
`define IOP_IDX_PA_CHG 6'h08
`define IOP_IDX_PB_CHG 6'h09
`define IOP_IDX_PWR 6'h0A
`define IOP_IDX_IRQ 6'h0B
`define IOP_IDX_EDGE 6'h0C
`define IOP_IDX_ALT 6'h0D
`define IOP_IDX_TSEL 6'h0E
`define IOP_IDX_PWMB 6'h16

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IOP_PWR_PA5_PU 4
`define IOP_IRQ_FLAG 0
`define IOP_IRQ_EN 1
`define IOP_IRQ_GIE 2
`define IOP_EDGE_E0_LO 0
`define IOP_EDGE_E1_LO 2
`define IOP_EDGE_SEL0 4
`define IOP_EDGE_SEL1 5
`define IOP_ALT_IR 0
`define IOP_ALT_CMP 1
`define IOP_ALT_PWM1 2
`define IOP_ALT_BZ1 3
`define IOP_ALT_PWM2 4
`define IOP_ALT_BZ2 5
`define IOP_ALT_TIMER_ZERO_SOURCE_SEL 6
`define IOP_ALT_T0LCK 7
`define IOP_TSEL_TIMER_ONE_SOURCE_SEL 0
`define IOP_TSEL_T2CS 1
`define IOP_TSEL_T3CS 2
`define IOP_PWMB_POL 6
`define IOP_PWMB_EN 7

// ----------------------------------------------------------------
// reset values and bus response codes
// ----------------------------------------------------------------
`define IOP_RST_DIR 8'hFF
`define IOP_RST_ZERO 8'h00
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

//--- iop_pkg.sv
package iop_pkg;

  // peripheral waveforms that may take over a pin
  typedef struct packed {
    logic pwmBWave;
    logic irCarrier;
    logic cmpOut;
    logic pwmOneWave;
    logic buzzOneWave;
    logic pwmTwoWave;
    logic buzzTwoWave;
    logic instrClk;
  } iop_alt_s;

  // static configuration-word settings
  typedef struct packed {
    logic pwmBOnPa7;
    logic extResetEnable;
    logic crystalEnable;
    logic clockOutEnable;
  } iop_cfg_s;

  typedef logic [7:0] iop_byte_t;

endpackage : iop_pkg

//--- iop_port_ctrl.sv
`timescale 1ns/1ps
`include "iop_consts.svh"
// Behaviour
// (R1) pwm_b polarity bit 1 drives the pwm_b waveform active low, else active high.
// (R2) pwm_b pin enable routes the waveform to PA3 or PA7 by configuration.
// (R3) fourteen pins, eight on port A and six on port B, through data registers.
// (R4) each pin has its own direction bit in the port direction registers.
// (R5) pull resistors act only on input pins, each with its own enable bit.
// (R6) port A pull-ups from bits 7:6,4:0; PA5 pull-up from power control bit 4.
// (R7) port B pull-ups come from six bits, one per pin PB5..PB0.
// (R8) pull-downs: shared bits 3:0 to PA3..0, 7:4 to PB3..0; PA5 from pull-up bit 5.
// (R9) port B output pins use open-drain drive when their open-drain bit is set.
// (R10) level change on any selected pin sets the level change flag.
// (R11) level change request only while flag, its enable and global enable are 1.
// (R12) edge bit 4 makes PB0 external interrupt 0, edge chosen by bits 1:0.
// (R13) edge bit 5 makes PB1 external interrupt 1 input.
// (R14) external interrupt on PB0/PB1 disables that pin's level change detection.
// (R15) IR carrier enable drives the carrier on PB1; otherwise no carrier.
// (R16) PA5 may be an active-low external reset input by configuration.
// (R17) external crystal takes PA6 as crystal input and PA7 as crystal output.
// (R18) internal oscillators with clock-out configured put instruction clock on PA7.
// (R19) PA4 feeds timer 0 (external, low-clock 0) and timer 1 (source bit 1).
// (R20) PA1 feeds timers 2 and 3 when either source select bit is 1.
// (R21) PB3 priority: comparator, then pwm one, then buzzer one, each enabled.
// (R22) PB2 priority: pwm two over buzzer two, each enabled.
// (R23) external interrupt 1 edge selected by edge register bits 3:2.
// (R24) selected pins compare against previous sample each cycle; differences flag.
module iop_port_ctrl #(
  parameter int PA_WIDTH = 8,
  parameter int PB_WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire iop_pkg::iop_alt_s altIn,
  input wire iop_pkg::iop_cfg_s cfgIn,
  input wire logic [PA_WIDTH-1:0] portAIn,
  output logic [PA_WIDTH-1:0] portAOut,
  output logic [PA_WIDTH-1:0] portAOe,
  output logic [PA_WIDTH-1:0] portAPullUp,
  output logic [PA_WIDTH-1:0] portAPullDown,
  input wire logic [PB_WIDTH-1:0] portBIn,
  output logic [PB_WIDTH-1:0] portBOut,
  output logic [PB_WIDTH-1:0] portBOe,
  output logic [PB_WIDTH-1:0] portBPullUp,
  output logic [PB_WIDTH-1:0] portBPullDown,
  output logic extClockInA,
  output logic extClockInB,
  output logic extIrqZeroPulse,
  output logic extIrqOnePulse,
  output logic levelChangeIrq,
  output logic extResetReq_n
);
  import iop_pkg::*;

  if (PA_WIDTH != 8 || PB_WIDTH != 6) begin : gWidthCheck
    $error("port widths are fixed by the pin function map");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire logic rstLocal_n = rstSync_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  iop_byte_t portADataLatch_reg, portBDataLatch_reg;
  iop_byte_t portADirection_reg, portBDirection_reg;
  iop_byte_t portAPullupEnable_reg, portBPullupEnable_reg;
  iop_byte_t sharedPulldownEnable_reg, portBOpenDrain_reg;
  iop_byte_t portAChangeSelect_reg, portBChangeSelect_reg;
  iop_byte_t powerControl_reg, extIrqEdge_reg, altSelect_reg, timerSelect_reg;
  logic levelChangeIrqEnable_reg, globalIrqEnable_reg, levelChangeFlag_reg;
  logic pwmBPolarity_reg, pwmBPinEnable_reg;

  // ----------------------------------------------------------------
  // bus slave: address and data taken in either order
  // ----------------------------------------------------------------
  logic awHeld_reg, wHeld_reg;
  logic [5:0] wIdx_reg;
  logic [31:0] wData_reg;
  logic wLane_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;

  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready = !wHeld_reg && !bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  wire logic writeFire = awHeld_reg && wHeld_reg && !bValid_reg;

  function automatic logic idxMapped(input logic [5:0] idx);
    idxMapped = (idx <= `IOP_IDX_TSEL) || (idx == `IOP_IDX_PWMB);
  endfunction : idxMapped

  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wIdx_reg <= 6'h00;
      wData_reg <= 32'h0000_0000;
      wLane_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= `IOP_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        wIdx_reg <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wLane_reg <= s_axi_wstrb[0];
      end
      if (writeFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg <= idxMapped(wIdx_reg) ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end else if (bValid_reg && s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  wire logic doWrite = writeFire && wLane_reg && idxMapped(wIdx_reg);
  wire iop_byte_t wByte = wData_reg[7:0];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      portADataLatch_reg <= `IOP_RST_ZERO;
      portBDataLatch_reg <= `IOP_RST_ZERO;
      portADirection_reg <= `IOP_RST_DIR;
      portBDirection_reg <= `IOP_RST_DIR;
      portAPullupEnable_reg <= `IOP_RST_ZERO;
      portBPullupEnable_reg <= `IOP_RST_ZERO;
      sharedPulldownEnable_reg <= `IOP_RST_ZERO;
      portBOpenDrain_reg <= `IOP_RST_ZERO;
      portAChangeSelect_reg <= `IOP_RST_ZERO;
      portBChangeSelect_reg <= `IOP_RST_ZERO;
      powerControl_reg <= `IOP_RST_ZERO;
      extIrqEdge_reg <= `IOP_RST_ZERO;
      altSelect_reg <= `IOP_RST_ZERO;
      timerSelect_reg <= `IOP_RST_ZERO;
      levelChangeIrqEnable_reg <= 1'b0;
      globalIrqEnable_reg <= 1'b0;
      pwmBPolarity_reg <= 1'b0;
      pwmBPinEnable_reg <= 1'b0;
    end else if (clkEn && doWrite) begin
      unique case (wIdx_reg)
        `IOP_IDX_PA_DATA: portADataLatch_reg <= wByte; // [R3]
        `IOP_IDX_PB_DATA: portBDataLatch_reg <= {2'h0, wByte[5:0]}; // [R3]
        `IOP_IDX_PA_DIR: portADirection_reg <= wByte; // [R4]
        `IOP_IDX_PB_DIR: portBDirection_reg <= {2'h3, wByte[5:0]}; // [R4]
        `IOP_IDX_PA_PU: portAPullupEnable_reg <= wByte;
        `IOP_IDX_PB_PU: portBPullupEnable_reg <= {2'h0, wByte[5:0]};
        `IOP_IDX_PD: sharedPulldownEnable_reg <= wByte;
        `IOP_IDX_PB_OD: portBOpenDrain_reg <= {2'h0, wByte[5:0]};
        `IOP_IDX_PA_CHG: portAChangeSelect_reg <= wByte;
        `IOP_IDX_PB_CHG: portBChangeSelect_reg <= {2'h0, wByte[5:0]};
        `IOP_IDX_PWR: powerControl_reg <= wByte;
        `IOP_IDX_IRQ: begin
          levelChangeIrqEnable_reg <= wByte[`IOP_IRQ_EN];
          globalIrqEnable_reg <= wByte[`IOP_IRQ_GIE];
        end
        `IOP_IDX_EDGE: extIrqEdge_reg <= {2'h0, wByte[5:0]};
        `IOP_IDX_ALT: altSelect_reg <= wByte;
        `IOP_IDX_TSEL: timerSelect_reg <= {5'h00, wByte[2:0]};
        `IOP_IDX_PWMB: begin
          pwmBPolarity_reg <= wByte[`IOP_PWMB_POL];
          pwmBPinEnable_reg <= wByte[`IOP_PWMB_EN];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin sampling, level change and external interrupts
  // ----------------------------------------------------------------
  logic [PA_WIDTH-1:0] portAPrev_reg;
  logic [PB_WIDTH-1:0] portBPrev_reg;
  wire logic extZeroOn = extIrqEdge_reg[`IOP_EDGE_SEL0];
  wire logic extOneOn = extIrqEdge_reg[`IOP_EDGE_SEL1];

  // PB0/PB1 drop out of change detection while they serve as interrupts
  wire logic [PB_WIDTH-1:0] portBChangeMask =
    portBChangeSelect_reg[PB_WIDTH-1:0] & ~{4'h0, extOneOn, extZeroOn}; // [R14]
  wire logic anyChange =
    |((portAIn ^ portAPrev_reg) & portAChangeSelect_reg) || // [R10] [R24]
    |((portBIn ^ portBPrev_reg) & portBChangeMask); // [R10] [R24]
  wire logic flagClear = doWrite && (wIdx_reg == `IOP_IDX_IRQ) && !wByte[`IOP_IRQ_FLAG];

  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      portAPrev_reg <= '0;
      portBPrev_reg <= '0;
    end else if (clkEn) begin
      portAPrev_reg <= portAIn; // [R24]
      portBPrev_reg <= portBIn; // [R24]
    end
  end

  // a change in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      levelChangeFlag_reg <= 1'b0;
    end else if (clkEn) begin
      if (anyChange) begin
        levelChangeFlag_reg <= 1'b1; // [R10]
      end else if (flagClear) begin
        levelChangeFlag_reg <= 1'b0;
      end
    end
  end

  assign levelChangeIrq =
    levelChangeFlag_reg && levelChangeIrqEnable_reg && globalIrqEnable_reg; // [R11]

  // edge code: 00 rising, 01 falling, 1x both
  function automatic logic edgeHit(input logic [1:0] mode, input logic now,
                                   input logic prev);
    edgeHit = mode[1] ? (now ^ prev) : (mode[0] ? (prev && !now) : (!prev && now));
  endfunction : edgeHit

  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      extIrqZeroPulse <= 1'b0;
      extIrqOnePulse <= 1'b0;
    end else if (clkEn) begin
      extIrqZeroPulse <= extZeroOn &&
        edgeHit(extIrqEdge_reg[`IOP_EDGE_E0_LO +: 2], portBIn[0], portBPrev_reg[0]); // [R12]
      extIrqOnePulse <= extOneOn &&
        edgeHit(extIrqEdge_reg[`IOP_EDGE_E1_LO +: 2], portBIn[1], portBPrev_reg[1]); // [R13] [R23]
    end
  end

  // ----------------------------------------------------------------
  // alternate functions
  // ----------------------------------------------------------------
  wire logic pwmBLevel = altIn.pwmBWave ^ pwmBPolarity_reg; // [R1]
  wire logic pwmBOnPa3 = pwmBPinEnable_reg && !cfgIn.pwmBOnPa7; // [R2]
  wire logic crystalOn = cfgIn.crystalEnable; // [R17]
  wire logic clockOutOn = cfgIn.clockOutEnable && !crystalOn; // [R18]
  wire logic pwmBOnPa7 = pwmBPinEnable_reg && cfgIn.pwmBOnPa7 && !crystalOn; // [R2]
  wire logic resetPinOn = cfgIn.extResetEnable; // [R16]

  logic [PA_WIDTH-1:0] altEnA, altValA, lockA;
  logic [PB_WIDTH-1:0] altEnB, altValB;

  always_comb begin
    altEnA = '0;
    altValA = '0;
    lockA = '0;
    altEnA[3] = pwmBOnPa3; // [R2]
    altValA[3] = pwmBLevel;
    lockA[5] = resetPinOn; // [R16]
    lockA[6] = crystalOn; // [R17]
    lockA[7] = crystalOn; // [R17]
    altEnA[7] = clockOutOn || pwmBOnPa7; // [R18]
    altValA[7] = clockOutOn ? altIn.instrClk : pwmBLevel; // [R18]
  end

  always_comb begin
    altEnB = '0;
    altValB = '0;
    altEnB[1] = altSelect_reg[`IOP_ALT_IR]; // [R15]
    altValB[1] = altIn.irCarrier;
    altEnB[2] = altSelect_reg[`IOP_ALT_PWM2] || altSelect_reg[`IOP_ALT_BZ2]; // [R22]
    altValB[2] = altSelect_reg[`IOP_ALT_PWM2] ? altIn.pwmTwoWave : altIn.buzzTwoWave; // [R22]
    altEnB[3] = altSelect_reg[`IOP_ALT_CMP] || altSelect_reg[`IOP_ALT_PWM1] ||
                altSelect_reg[`IOP_ALT_BZ1]; // [R21]
    if (altSelect_reg[`IOP_ALT_CMP]) begin
      altValB[3] = altIn.cmpOut; // [R21]
    end else if (altSelect_reg[`IOP_ALT_PWM1]) begin
      altValB[3] = altIn.pwmOneWave; // [R21]
    end else begin
      altValB[3] = altIn.buzzOneWave; // [R21]
    end
  end

  // ----------------------------------------------------------------
  // pad drive, pulls and clock taps
  // ----------------------------------------------------------------
  logic [PA_WIDTH-1:0] puSelA, pdSelA;
  always_comb begin
    puSelA = portAPullupEnable_reg; // [R6]
    puSelA[5] = powerControl_reg[`IOP_PWR_PA5_PU]; // [R6]
    pdSelA = {2'h0, portAPullupEnable_reg[5], 1'b0, sharedPulldownEnable_reg[3:0]}; // [R8]
  end
  wire logic [PB_WIDTH-1:0] puSelB = portBPullupEnable_reg[PB_WIDTH-1:0]; // [R7]
  wire logic [PB_WIDTH-1:0] pdSelB = {2'h0, sharedPulldownEnable_reg[7:4]}; // [R8]

  for (genvar i = 0; i < PA_WIDTH; i++) begin : gPortA
    wire logic val = altEnA[i] ? altValA[i] : portADataLatch_reg[i];
    wire logic drive = !lockA[i] && (altEnA[i] || !portADirection_reg[i]); // [R4]
    // PA5 can only sink
    wire logic oe = (i == 5) ? (drive && !val) : drive;
    wire logic isInput = !lockA[i] && !drive && portADirection_reg[i];
    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
        portAOut[i] <= 1'b0;
        portAOe[i] <= 1'b0;
        portAPullUp[i] <= 1'b0;
        portAPullDown[i] <= 1'b0;
      end else if (clkEn) begin
        portAOut[i] <= (i == 5) ? 1'b0 : val;
        portAOe[i] <= oe;
        portAPullUp[i] <= isInput && puSelA[i]; // [R5]
        portAPullDown[i] <= isInput && pdSelA[i]; // [R5]
      end
    end
  end

  for (genvar i = 0; i < PB_WIDTH; i++) begin : gPortB
    wire logic val = altEnB[i] ? altValB[i] : portBDataLatch_reg[i];
    wire logic drive = altEnB[i] || !portBDirection_reg[i]; // [R4]
    wire logic oe = drive && (!portBOpenDrain_reg[i] || !val); // [R9]
    wire logic isInput = !drive;
    always_ff @(posedge clk_sys or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
        portBOut[i] <= 1'b0;
        portBOe[i] <= 1'b0;
        portBPullUp[i] <= 1'b0;
        portBPullDown[i] <= 1'b0;
      end else if (clkEn) begin
        portBOut[i] <= val;
        portBOe[i] <= oe;
        portBPullUp[i] <= isInput && puSelB[i]; // [R5]
        portBPullDown[i] <= isInput && pdSelB[i]; // [R5]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      extClockInA <= 1'b0;
      extClockInB <= 1'b0;
      extResetReq_n <= 1'b1;
    end else if (clkEn) begin
      extClockInA <= portAIn[4] && ((altSelect_reg[`IOP_ALT_TIMER_ZERO_SOURCE_SEL] &&
        !altSelect_reg[`IOP_ALT_T0LCK]) || timerSelect_reg[`IOP_TSEL_TIMER_ONE_SOURCE_SEL]); // [R19]
      extClockInB <= portAIn[1] && (timerSelect_reg[`IOP_TSEL_T2CS] ||
        timerSelect_reg[`IOP_TSEL_T3CS]); // [R20]
      extResetReq_n <= !(resetPinOn && !portAIn[5]); // [R16]
    end
  end

  // ----------------------------------------------------------------
  // read path: input pins read the pad, output pins the latch
  // ----------------------------------------------------------------
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  iop_byte_t rByte;
  logic [5:0] rIdx;
  assign rIdx = s_axi_araddr[7:2];
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  always_comb begin
    rByte = 8'h00;
    unique case (rIdx)
      `IOP_IDX_PA_DATA: rByte = (portADirection_reg & portAIn) |
                                (~portADirection_reg & portADataLatch_reg); // [R3]
      `IOP_IDX_PB_DATA: rByte = {2'h0, (portBDirection_reg[5:0] & portBIn) |
                                (~portBDirection_reg[5:0] & portBDataLatch_reg[5:0])}; // [R3]
      `IOP_IDX_PA_DIR: rByte = portADirection_reg;
      `IOP_IDX_PB_DIR: rByte = {2'h0, portBDirection_reg[5:0]};
      `IOP_IDX_PA_PU: rByte = portAPullupEnable_reg;
      `IOP_IDX_PB_PU: rByte = portBPullupEnable_reg;
      `IOP_IDX_PD: rByte = sharedPulldownEnable_reg;
      `IOP_IDX_PB_OD: rByte = portBOpenDrain_reg;
      `IOP_IDX_PA_CHG: rByte = portAChangeSelect_reg;
      `IOP_IDX_PB_CHG: rByte = portBChangeSelect_reg;
      `IOP_IDX_PWR: rByte = powerControl_reg;
      `IOP_IDX_IRQ: rByte = {5'h00, globalIrqEnable_reg, levelChangeIrqEnable_reg,
                             levelChangeFlag_reg};
      `IOP_IDX_EDGE: rByte = extIrqEdge_reg;
      `IOP_IDX_ALT: rByte = altSelect_reg;
      `IOP_IDX_TSEL: rByte = timerSelect_reg;
      `IOP_IDX_PWMB: rByte = {pwmBPinEnable_reg, pwmBPolarity_reg, 6'h00};
      default: rByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= `IOP_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rValid_reg <= 1'b1;
        rData_reg <= {24'h00_0000, rByte};
        rResp_reg <= idxMapped(rIdx) ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end else if (rValid_reg && s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end
  end

endmodule : iop_port_ctrl

//--- iop_port_ctrl_chk.sv
`timescale 1ns/1ps
module iop_port_ctrl_chk #(
  parameter int PA_WIDTH = 8,
  parameter int PB_WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [PA_WIDTH-1:0] portAIn,
  input wire logic [PA_WIDTH-1:0] portAOe,
  input wire logic [PA_WIDTH-1:0] portAPullUp,
  input wire logic [PA_WIDTH-1:0] portAPullDown,
  input wire logic [PB_WIDTH-1:0] portBOe,
  input wire logic [PB_WIDTH-1:0] portBPullUp,
  input wire logic [PB_WIDTH-1:0] portBPullDown,
  input wire logic extClockInA,
  input wire logic extClockInB,
  input wire logic extResetReq_n
);
  // ----------------------------------------------------------------
  // pin and bus relations
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pa_pull_input: assert property (((portAPullUp | portAPullDown) & portAOe) == '0)
    else $error("pull active on driven port A pin");
  a_pb_pull_input: assert property (((portBPullUp | portBPullDown) & portBOe) == '0)
    else $error("pull active on driven port B pin");
  a_pa_pulldown_map: assert property (portAPullDown[7:6] == 2'h0 && !portAPullDown[4])
    else $error("pull-down on port A pin without one");
  a_pb_pulldown_map: assert property (portBPullDown[5:4] == 2'h0)
    else $error("pull-down on PB5 or PB4");
  a_clock_a_copy: assert property (extClockInA |-> $past(portAIn[4]))
    else $error("timer 0/1 clock high without PA4 high");
  a_clock_b_copy: assert property (extClockInB |-> $past(portAIn[1]))
    else $error("timer 2/3 clock high without PA1 high");
  a_reset_req: assert property (!extResetReq_n |-> !$past(portAIn[5]))
    else $error("reset request without PA5 low");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule : iop_port_ctrl_chk

bind iop_port_ctrl iop_port_ctrl_chk #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH)) i_chk (.*);

//--- iop_port_ctrl_tb.sv
`timescale 1ns/1ps
module iop_port_ctrl_tb;
  import iop_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic clkEn = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bResp, rdResp;
  iop_alt_s altIn = 8'hEA;
  iop_cfg_s cfgIn = '0;
  logic [7:0] portAIn = '0, portAOut, portAOe, portAPullUp, portAPullDown;
  logic [5:0] portBIn = '0, portBOut, portBOe, portBPullUp, portBPullDown;
  logic extClockInA, extClockInB, extIrqZeroPulse, extIrqOnePulse, levelChangeIrq, extResetReq_n;
  int errTotal = 0, checkCount = 0, p0 = 0, p1 = 0;

  iop_port_ctrl i_iop_port_ctrl (.*);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    p0 <= p0 + extIrqZeroPulse;
    p1 <= p1 + extIrqOnePulse;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk
  // ready is sampled mid-cycle since inputs only move at rising edges
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w, b;
    @(posedge clk_sys);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk_sys);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      bResp = s_axi_bresp;
      @(posedge clk_sys);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (!b);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [5:0] i);
    logic a, v;
    @(posedge clk_sys);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk_sys);
      a = s_axi_arready;
      v = s_axi_rvalid;
      rdVal = s_axi_rdata;
      rdResp = s_axi_rresp;
      @(posedge clk_sys);
      if (a) s_axi_arvalid <= 1'h0;
    end while (!v);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic st;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : st
  task automatic tog(input int b);
    @(posedge clk_sys) portBIn[b] <= ~portBIn[b];
    repeat (4) @(posedge clk_sys);
  endtask : tog
  task report_and_stop;
    $display("checks=%0d errors=%0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [5:0] ri [4] = '{6'h02, 6'h03, 6'h0B, 6'h0F};
    logic [9:0] re [4] = '{10'h0FF, 10'h03F, 10'h000, 10'h200};
    for (int k = 0; k < 4; k++) begin
      rd(ri[k]);
      chk({rdResp, rdVal[7:0]}, re[k]);
    end
    wr(6'h0F, 8'h55);
    chk(bResp, 2'h2);
  endtask : t_regs
  task automatic t_pulls;
    wr(6'h04, 8'hFF);
    wr(6'h0A, 8'h10);
    wr(6'h06, 8'hFF);
    wr(6'h05, 8'h3F);
    st;
    chk({portAPullUp, portAPullDown, portBPullUp, portBPullDown}, 28'hFF2FFCF);
    wr(6'h0A, 8'h00);
    st;
    chk(portAPullUp, 8'hDF);
  endtask : t_pulls
  task automatic t_change;
    wr(6'h08, 8'h01);
    wr(6'h0B, 8'h06);
    @(posedge clk_sys) portAIn[0] <= 1'h1;
    st;
    chk(levelChangeIrq, 1'h1);
    wr(6'h0B, 8'h02);
    @(posedge clk_sys) portAIn[0] <= 1'h0;
    st;
    chk(levelChangeIrq, 1'h0);
    rd(6'h0B);
    chk(rdVal[2:0], 3'h3);
    wr(6'h0B, 8'h06);
  endtask : t_change
  task automatic t_ext;
    int c;
    wr(6'h09, 8'h01);
    wr(6'h0C, 8'h10);
    c = p0;
    tog(0);
    chk(p0 - c, 1);
    tog(0);
    st;
    chk(p0 - c, 1);
    chk(levelChangeIrq, 1'h0);
    wr(6'h0C, 8'h24);
    c = p1;
    tog(1);
    chk(p1 - c, 0);
    tog(1);
    st;
    chk(p1 - c, 1);
    wr(6'h0C, 8'h12);
    c = p0;
    tog(0);
    tog(0);
    st;
    chk(p0 - c, 2);
  endtask : t_ext
  task automatic t_alt;
    logic [7:0] av [4] = '{8'h2F, 8'h3C, 8'h08, 8'h00};
    logic [5:0] ae [4] = '{6'h3F, 6'h30, 6'h24, 6'h00};
    logic [7:0] pv [3] = '{8'h80, 8'hC0, 8'h00};
    logic [1:0] pe [3] = '{2'h3, 2'h2, 2'h0};
    for (int k = 0; k < 4; k++) begin
      wr(6'h0D, av[k]);
      st;
      chk({portBOe[3:1], portBOut[3:1] & portBOe[3:1]}, ae[k]);
    end
    for (int k = 0; k < 3; k++) begin
      wr(6'h16, pv[k]);
      st;
      chk({portAOe[3], portAOut[3] & portAOe[3]}, pe[k]);
    end
    @(posedge clk_sys) cfgIn <= 4'h8;
    wr(6'h16, 8'h80);
    st;
    chk({portAOe[7], portAOut[7], portAOe[3]}, 3'h6);
    @(posedge clk_sys) cfgIn <= 4'h9;
    st;
    chk({portAOe[7:6], portAOut[7]}, 3'h4);
    @(posedge clk_sys) cfgIn <= 4'hB;
    st;
    chk({portAOe[7:6], portAPullUp[7:6]}, 4'h0);
    @(posedge clk_sys) cfgIn <= '0;
    wr(6'h16, 8'h00);
  endtask : t_alt
  task automatic t_dir;
    wr(6'h02, 8'h00);
    wr(6'h00, 8'hA5);
    wr(6'h03, 8'h00);
    wr(6'h07, 8'h01);
    wr(6'h01, 8'h3F);
    st;
    chk({portAOe, portAOut, portBOe}, 22'h37E17E);
    chk({portAPullUp, portAPullDown, portBPullUp, portBPullDown}, 0);
    rd(6'h00);
    chk(rdVal & 32'hDF, 32'h85);
    @(posedge clk_sys) portAIn <= 8'h13;
    cfgIn.extResetEnable <= 1'h1;
    wr(6'h0D, 8'h40);
    wr(6'h0E, 8'h02);
    st;
    chk({extClockInA, extClockInB, extResetReq_n}, 3'h6);
  endtask : t_dir

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_pulls;
    t_change;
    t_ext;
    t_alt;
    t_dir;
    report_and_stop;
  end
  // whole run needs well under 2000 cycles
  initial begin
    #100000;
    errTotal++;
    report_and_stop;
  end
endmodule : iop_port_ctrl_tb
